// File: inc/cmcfg_pkg.sv
// Register map, field positions and reset values of the clock multiplier configuration bank
package cmcfg_pkg;
   // ==========================================
   // Register addresses
   localparam logic [7:0] ADDR_DEVICE_CONTROL = 8'h02;
   localparam logic [7:0] ADDR_DEVICE_CONFIGURATION_ONE = 8'h03;
   localparam logic [7:0] ADDR_GLOBAL_CONFIGURATION = 8'h05;
   localparam logic [7:0] ADDR_USER_RATIO_0 = 8'h06;
   localparam logic [7:0] ADDR_USER_RATIO_1 = 8'h07;
   localparam logic [7:0] ADDR_USER_RATIO_2 = 8'h08;
   localparam logic [7:0] ADDR_USER_RATIO_3 = 8'h09;
   localparam logic [7:0] ADDR_FUNCTION_CONFIGURATION_ONE = 8'h16;
   localparam logic [7:0] ADDR_FUNCTION_CONFIGURATION_TWO = 8'h17;
   // ==========================================
   // Field positions
   localparam int UNLOCK_BIT = 7;
   localparam int AUX_DISABLE_BIT = 1;
   localparam int CLK_DISABLE_BIT = 0;
   localparam int RATIO_SCALE_LSB = 5;
   localparam int AUX_SOURCE_LSB = 1;
   localparam int PORT_ENABLE_A_BIT = 0;
   localparam int FREEZE_BIT = 3;
   localparam int PORT_ENABLE_B_BIT = 0;
   localparam int SKIP_ENABLE_BIT = 7;
   localparam int LOCK_PIN_STYLE_BIT = 6;
   localparam int REF_DIVIDER_LSB = 3;
   localparam int OUTPUT_ON_UNLOCK_BIT = 4;
   localparam int RATIO_FORMAT_BIT = 3;
   // ==========================================
   // Writable masks and reset values
   localparam logic [7:0] MASK_DEVICE_CONTROL = 8'h03;
   localparam logic [7:0] MASK_DEVICE_CONFIGURATION_ONE = 8'he7;
   localparam logic [7:0] MASK_GLOBAL_CONFIGURATION = 8'h09;
   localparam logic [7:0] MASK_FUNCTION_CONFIGURATION_ONE = 8'hd8;
   localparam logic [7:0] MASK_FUNCTION_CONFIGURATION_TWO = 8'h18;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [31:0] RESET_RATIO = 32'h0000_0000;
   // ==========================================
   // Source and reference divider codes
   localparam logic [1:0] AUX_SRC_REF = 2'h0;
   localparam logic [1:0] AUX_SRC_INPUT = 2'h1;
   localparam logic [1:0] AUX_SRC_OUTPUT = 2'h2;
   localparam logic [1:0] AUX_SRC_LOCK = 2'h3;
   localparam logic [1:0] REF_DIV_FOUR = 2'h0;
   localparam logic [1:0] REF_DIV_TWO = 2'h1;
   localparam logic [1:0] REF_DIV_ONE = 2'h2;
endpackage

// File: src/cmcfg_ratio_scale.sv
// Ratio modifier shifter for the user ratio
`timescale 1ns/1ps
module cmcfg_ratio_scale (
   // Operands
   input wire logic [31:0] ratio,
   input wire logic [2:0] scale_select,
   // Result
   output logic [35:0] scaled_ratio
);
   wire [35:0] ratio_wide = {4'h0, ratio};
   assign scaled_ratio = scale_select[2] ?
      (ratio_wide >> ({1'b0, scale_select[1:0]} + 3'h1)) :
      (ratio_wide << scale_select[1:0]);
endmodule

// File: src/cmcfg_regs.sv
// Configuration register bank of the fractional-N clock multiplier
`timescale 1ns/1ps
module cmcfg_regs (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic nrst,
   // Register port from the serial control port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [7:0] reg_rdata,
   // Loop and clock sources
   input wire logic pll_locked,
   input wire logic ref_clk_in,
   input wire logic input_clk_in,
   input wire logic pll_clk_in,
   // Auxiliary pin
   output logic aux_out,
   output logic aux_out_en_n,
   // Clock output pin
   output logic clk_out,
   output logic clk_out_en_n,
   // Applied settings toward the loop
   output logic normal_operation,
   output logic [35:0] effective_ratio,
   output logic ratio_format_select,
   output logic skip_tolerance_enable,
   output logic [1:0] reference_divider_select
);
   // ==========================================
   // Storage
   logic [7:0] device_control_reg, device_configuration_one_reg;
   logic [7:0] global_configuration_reg;
   logic [31:0] user_ratio_reg;
   logic [7:0] function_configuration_one_reg, function_configuration_two_reg;
   logic [7:0] active_control_reg, active_configuration_reg;
   logic unlock_sticky_reg;
   logic [7:0] rdata_reg;

   wire wr_ctrl = reg_write && reg_addr == cmcfg_pkg::ADDR_DEVICE_CONTROL;
   wire wr_cfg1 = reg_write && reg_addr == cmcfg_pkg::ADDR_DEVICE_CONFIGURATION_ONE;
   wire wr_glob = reg_write && reg_addr == cmcfg_pkg::ADDR_GLOBAL_CONFIGURATION;
   wire wr_fc1 = reg_write && reg_addr == cmcfg_pkg::ADDR_FUNCTION_CONFIGURATION_ONE;
   wire wr_fc2 = reg_write && reg_addr == cmcfg_pkg::ADDR_FUNCTION_CONFIGURATION_TWO;
   wire rd_ctrl = reg_read && reg_addr == cmcfg_pkg::ADDR_DEVICE_CONTROL;
   wire freeze = global_configuration_reg[cmcfg_pkg::FREEZE_BIT];
   wire [7:0] ctrl_wval = reg_wdata & cmcfg_pkg::MASK_DEVICE_CONTROL;
   wire [7:0] cfg1_wval = reg_wdata & cmcfg_pkg::MASK_DEVICE_CONFIGURATION_ONE;
   wire [7:0] glob_wval = reg_wdata & cmcfg_pkg::MASK_GLOBAL_CONFIGURATION;

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         device_control_reg <= cmcfg_pkg::RESET_BYTE;
         device_configuration_one_reg <= cmcfg_pkg::RESET_BYTE;
         global_configuration_reg <= cmcfg_pkg::RESET_BYTE;
         user_ratio_reg <= cmcfg_pkg::RESET_RATIO;
         function_configuration_one_reg <= cmcfg_pkg::RESET_BYTE;
         function_configuration_two_reg <= cmcfg_pkg::RESET_BYTE;
      end else begin
         if (wr_ctrl) device_control_reg <= ctrl_wval;
         if (wr_cfg1) device_configuration_one_reg <= cfg1_wval;
         if (wr_glob) global_configuration_reg <= glob_wval;
         if (reg_write && reg_addr == cmcfg_pkg::ADDR_USER_RATIO_0) user_ratio_reg[31:24] <= reg_wdata;
         if (reg_write && reg_addr == cmcfg_pkg::ADDR_USER_RATIO_1) user_ratio_reg[23:16] <= reg_wdata;
         if (reg_write && reg_addr == cmcfg_pkg::ADDR_USER_RATIO_2) user_ratio_reg[15:8] <= reg_wdata;
         if (reg_write && reg_addr == cmcfg_pkg::ADDR_USER_RATIO_3) user_ratio_reg[7:0] <= reg_wdata;
         if (wr_fc1) function_configuration_one_reg <= reg_wdata & cmcfg_pkg::MASK_FUNCTION_CONFIGURATION_ONE;
         if (wr_fc2) function_configuration_two_reg <= reg_wdata & cmcfg_pkg::MASK_FUNCTION_CONFIGURATION_TWO;
      end
   end

   // ==========================================
   // Applied copies of 02h and 03h
   // unfrozen write lands in the applied copy the same edge
   // frozen writes only reach the shadow
   // release copies every shadow in one edge
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         active_control_reg <= cmcfg_pkg::RESET_BYTE;
         active_configuration_reg <= cmcfg_pkg::RESET_BYTE;
      end else if (!freeze) begin
         active_control_reg <= wr_ctrl ? ctrl_wval : device_control_reg;
         active_configuration_reg <= wr_cfg1 ? cfg1_wval : device_configuration_one_reg;
      end
   end

   // sticky unlock: a new unlock wins over the read clear
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         unlock_sticky_reg <= 1'b1;
      end else begin
         unlock_sticky_reg <= !pll_locked || (unlock_sticky_reg && !rd_ctrl);
      end
   end

   // ==========================================
   // Read path
   wire [7:0] ctrl_rval = {unlock_sticky_reg, device_control_reg[6:0]};
   wire [7:0] read_mux =
      (reg_addr == cmcfg_pkg::ADDR_DEVICE_CONTROL) ? ctrl_rval :
      (reg_addr == cmcfg_pkg::ADDR_DEVICE_CONFIGURATION_ONE) ? device_configuration_one_reg :
      (reg_addr == cmcfg_pkg::ADDR_GLOBAL_CONFIGURATION) ? global_configuration_reg :
      (reg_addr == cmcfg_pkg::ADDR_USER_RATIO_0) ? user_ratio_reg[31:24] :
      (reg_addr == cmcfg_pkg::ADDR_USER_RATIO_1) ? user_ratio_reg[23:16] :
      (reg_addr == cmcfg_pkg::ADDR_USER_RATIO_2) ? user_ratio_reg[15:8] :
      (reg_addr == cmcfg_pkg::ADDR_USER_RATIO_3) ? user_ratio_reg[7:0] :
      (reg_addr == cmcfg_pkg::ADDR_FUNCTION_CONFIGURATION_ONE) ? function_configuration_one_reg :
      (reg_addr == cmcfg_pkg::ADDR_FUNCTION_CONFIGURATION_TWO) ? function_configuration_two_reg :
      8'h00;

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         rdata_reg <= cmcfg_pkg::RESET_BYTE;
      end else if (reg_read) begin
         rdata_reg <= read_mux;
      end
   end
   assign reg_rdata = rdata_reg;

   // ==========================================
   // Decoded applied fields
   wire [2:0] ratio_scale_select = active_configuration_reg[cmcfg_pkg::RATIO_SCALE_LSB +: 3];
   wire [1:0] aux_source_select = active_configuration_reg[cmcfg_pkg::AUX_SOURCE_LSB +: 2];
   wire port_enable_a = active_configuration_reg[cmcfg_pkg::PORT_ENABLE_A_BIT];
   wire port_enable_b = global_configuration_reg[cmcfg_pkg::PORT_ENABLE_B_BIT];
   wire lock_pin_style = function_configuration_one_reg[cmcfg_pkg::LOCK_PIN_STYLE_BIT];
   wire output_on_unlock = function_configuration_two_reg[cmcfg_pkg::OUTPUT_ON_UNLOCK_BIT];
   wire aux_disable = active_control_reg[cmcfg_pkg::AUX_DISABLE_BIT];
   wire clk_disable = active_control_reg[cmcfg_pkg::CLK_DISABLE_BIT];

   assign normal_operation = port_enable_a && port_enable_b;
   assign skip_tolerance_enable = function_configuration_one_reg[cmcfg_pkg::SKIP_ENABLE_BIT];
   assign reference_divider_select = function_configuration_one_reg[cmcfg_pkg::REF_DIVIDER_LSB +: 2];
   assign ratio_format_select = function_configuration_two_reg[cmcfg_pkg::RATIO_FORMAT_BIT];

   cmcfg_ratio_scale u_scale (
      .ratio(user_ratio_reg),
      .scale_select(ratio_scale_select),
      .scaled_ratio(effective_ratio)
   );

   // ==========================================
   // Output gating
   // gate clocks low while unlocked, unless kept on
   wire clocks_gated = !pll_locked && !output_on_unlock;
   wire pll_clk_gated = pll_clk_in && !clocks_gated;

   wire aux_clock_value =
      (aux_source_select == cmcfg_pkg::AUX_SRC_REF) ? ref_clk_in :
      (aux_source_select == cmcfg_pkg::AUX_SRC_INPUT) ? input_clk_in : pll_clk_gated;
   wire aux_is_lock = aux_source_select == cmcfg_pkg::AUX_SRC_LOCK;
   // push-pull high when unlocked; open-drain low when unlocked
   wire aux_lock_value = lock_pin_style ? 1'b0 : !pll_locked;
   wire aux_lock_float = lock_pin_style && pll_locked;
   // style only matters for the lock source
   assign aux_out = aux_is_lock ? aux_lock_value : aux_clock_value;
   assign aux_out_en_n = aux_disable || (aux_is_lock && aux_lock_float);
   assign clk_out = pll_clk_gated;
   assign clk_out_en_n = clk_disable;

   // ==========================================
   // Checks
   a_freeze_holds_cfg: assert property (@(posedge clk_sys) disable iff (!nrst)
      freeze |=> $stable(active_configuration_reg))
      else $error("applied configuration changed while frozen");
   a_unfrozen_write_now: assert property (@(posedge clk_sys) disable iff (!nrst)
      (!freeze && wr_cfg1) |=> active_configuration_reg == $past(cfg1_wval))
      else $error("unfrozen write not applied");
   a_release_applies_all: assert property (@(posedge clk_sys) disable iff (!nrst)
      ($fell(freeze) && !wr_ctrl && !wr_cfg1) |=> (active_control_reg == $past(device_control_reg)
      && active_configuration_reg == $past(device_configuration_one_reg)))
      else $error("frozen values not applied together");
   // Settled enables may only drop through a write or a freeze release
   a_enable_pair: assert property (@(posedge clk_sys) disable iff (!nrst)
      (normal_operation && !wr_cfg1 && !wr_glob && !freeze && !$past(freeze))
      |=> normal_operation)
      else $error("normal operation dropped without a write");
   a_unlock_sticky: assert property (@(posedge clk_sys) disable iff (!nrst)
      (!pll_locked) |=> unlock_sticky_reg)
      else $error("unlock not captured");
   a_unlock_hold: assert property (@(posedge clk_sys) disable iff (!nrst)
      (unlock_sticky_reg && !rd_ctrl) |=> unlock_sticky_reg)
      else $error("unlock cleared without read");
   a_lock_push_pull: assert property (@(posedge clk_sys) disable iff (!nrst)
      (aux_is_lock && !lock_pin_style && !aux_disable) |-> (!aux_out_en_n && aux_out == !pll_locked))
      else $error("push-pull lock output wrong");
   a_lock_open_drain: assert property (@(posedge clk_sys) disable iff (!nrst)
      (aux_is_lock && lock_pin_style) |-> (pll_locked ? aux_out_en_n : (aux_out == 1'b0)))
      else $error("open-drain lock output wrong");
   a_clock_gate_low: assert property (@(posedge clk_sys) disable iff (!nrst)
      (!pll_locked && !output_on_unlock) |-> !clk_out)
      else $error("clock not forced low while unlocked");
   a_ratio_byte_order: assert property (@(posedge clk_sys) disable iff (!nrst)
      (reg_write && reg_addr == cmcfg_pkg::ADDR_USER_RATIO_0) |=> user_ratio_reg[31:24] == $past(reg_wdata))
      else $error("ratio MSB byte misplaced");
endmodule

// File: verif/cmcfg_host_model.sv
// Host model issuing byte accesses on the control port
`timescale 1ns/1ps
module cmcfg_host_model (
   // Clock
   input wire logic clk_sys,
   // Register port
   output logic [7:0] reg_addr,
   output logic [7:0] reg_wdata,
   output logic reg_write,
   output logic reg_read,
   input wire logic [7:0] reg_rdata
);
   initial begin
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_write = 1'b0;
      reg_read = 1'b0;
   end
   // ==========================================
   // Access tasks
   // enables written in caller order
   task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clk_sys);
      reg_write <= 1'b0;
      // Released lines must not keep the old value
      reg_addr <= ~a;
      reg_wdata <= ~d;
      #1;
   endtask
   task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clk_sys);
      reg_read <= 1'b0;
      reg_addr <= ~a;
      #1;
      d = reg_rdata;
   endtask
endmodule

// File: verif/tb_cmcfg_regs.sv
// Self-checking testbench of the configuration register bank
`timescale 1ns/1ps
module tb_cmcfg_regs;
   localparam logic [31:0] RATIO = 32'hf234_56a9;
   logic clk_sys, nrst, pll_locked, ref_clk_in, input_clk_in, pll_clk_in;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, rd;
   logic reg_write, reg_read, aux_out, aux_out_en_n, clk_out, clk_out_en_n;
   logic normal_operation, ratio_format_select, skip_tolerance_enable;
   logic [1:0] reference_divider_select;
   logic [35:0] effective_ratio, exp_ratio;
   int err_count = 0;
   int n_tests = 0;
   int cycles = 0;
   cmcfg_regs DUT (.clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
      .reg_rdata(reg_rdata), .pll_locked(pll_locked), .ref_clk_in(ref_clk_in),
      .input_clk_in(input_clk_in), .pll_clk_in(pll_clk_in), .aux_out(aux_out),
      .aux_out_en_n(aux_out_en_n), .clk_out(clk_out), .clk_out_en_n(clk_out_en_n),
      .normal_operation(normal_operation), .effective_ratio(effective_ratio),
      .ratio_format_select(ratio_format_select),
      .skip_tolerance_enable(skip_tolerance_enable),
      .reference_divider_select(reference_divider_select));
   cmcfg_host_model host (.clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata));
   // ==========================================
   // Helpers
   task automatic chk(input string name, input logic [35:0] seen, input logic [35:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_count++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      host.write_reg(a, d);
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
      host.read_reg(a, rd);
      chk("rdata", rd, exp);
   endtask
   // Order: lock, reference, input clock, loop clock
   task automatic set_src(input logic [3:0] v);
      @(posedge clk_sys);
      {pll_locked, ref_clk_in, input_clk_in, pll_clk_in} <= v;
      #1;
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // ==========================================
   // Clock and watchdog
   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         err_count++;
         print_verdict();
      end
   end
   // ==========================================
   // Main sequence
   initial begin
      nrst = 1'b0;
      {pll_locked, ref_clk_in, input_clk_in, pll_clk_in} = 4'h0;
      repeat (12) @(posedge clk_sys);
      nrst <= 1'b1;
      set_src(4'h8);
      rdchk(8'h02, 8'h80); // sticky from reset
      rdchk(8'h02, 8'h00); // cleared by read
      set_src(4'h0);
      set_src(4'h8);
      rdchk(8'h02, 8'h80); // held after relock
      rdchk(8'h03, 8'h00); // enable clear from reset
      rdchk(8'h16, 8'h00); // skip off from reset
      wr(8'h05, 8'h01);
      chk("normal", normal_operation, 0); // one enable only
      wr(8'h03, 8'h01);
      chk("normal", normal_operation, 1); // both enables
      wr(8'h06, RATIO[31:24]);
      wr(8'h07, RATIO[23:16]);
      wr(8'h08, RATIO[15:8]);
      wr(8'h09, RATIO[7:0]);
      rdchk(8'h06, RATIO[31:24]); // first byte on top
      for (int s = 0; s < 8; s++) begin
         wr(8'h03, 8'(s << 5) | 8'h01);
         exp_ratio = (s < 4) ? ({4'h0, RATIO} << s) : ({4'h0, RATIO} >> (s - 3));
         chk("ratio", effective_ratio, exp_ratio); // scaled ratio
      end
      for (int k = 0; k < 3; k++) begin
         wr(8'h03, {5'h0, k[1:0], 1'b1});
         set_src({1'b1, 3'b100 >> k});
         chk("aux", aux_out, 1); // selected source
         set_src({1'b1, ~(3'b100 >> k)});
         chk("aux", aux_out, 0); // selected source
      end
      wr(8'h03, 8'h07);
      for (int st = 0; st < 2; st++) begin
         wr(8'h16, {1'b0, st[0], 6'h0});
         for (int lk = 0; lk < 2; lk++) begin
            set_src({lk[0], 3'b000});
            chk("aux_en", aux_out_en_n, st & lk); // driver style
            if (!(st & lk))
               chk("aux", aux_out, st ? 0 : !lk); // pin level
         end
      end
      wr(8'h03, 8'h01);
      set_src(4'h4);
      chk("aux", aux_out, 1); // style ignored
      chk("aux_en", aux_out_en_n, 0); // style ignored
      wr(8'h02, 8'h02);
      chk("aux_en", aux_out_en_n, 1); // aux driver off at once
      wr(8'h02, 8'h00);
      chk("aux_en", aux_out_en_n, 0); // aux driver back at once
      for (int d = 0; d < 3; d++) begin
         wr(8'h16, 8'h80 | 8'(d << 3));
         chk("div", reference_divider_select, d); // divider code
         chk("skip", skip_tolerance_enable, 1); // skip on
      end
      // input clock held static while skipping
      wr(8'h16, 8'h00);
      chk("skip", skip_tolerance_enable, 0); // skip off
      set_src(4'h1);
      chk("clk", clk_out, 0); // gated while unlocked
      wr(8'h17, 8'h10);
      chk("clk", clk_out, 1); // running while unlocked
      wr(8'h17, 8'h08);
      chk("fmt", ratio_format_select, 1); // format bit
      chk("clk", clk_out, 0); // gated again
      wr(8'h05, 8'h09);
      wr(8'h03, 8'h21);
      wr(8'h02, 8'h01);
      chk("ratio", effective_ratio, {4'h0, RATIO}); // held while frozen
      chk("clk_en", clk_out_en_n, 0); // held while frozen
      wr(8'h05, 8'h01);
      @(posedge clk_sys);
      #1;
      chk("ratio", effective_ratio, {4'h0, RATIO} << 1); // applied together
      chk("clk_en", clk_out_en_n, 1); // applied together
      wr(8'h02, 8'h00);
      chk("clk_en", clk_out_en_n, 0); // immediate when unfrozen
      wr(8'h03, 8'hff);
      rdchk(8'h03, 8'he7); // fields read back
      rdchk(8'h40, 8'h00);
      // Mid-run reset with the loop locked: sticky unlock must come back set
      @(posedge clk_sys);
      nrst <= 1'b0;
      set_src(4'h8);
      @(posedge clk_sys);
      nrst <= 1'b1;
      #1;
      chk("normal", normal_operation, 0); // enables cleared by reset
      chk("ratio", effective_ratio, 0); // ratio cleared by reset
      chk("fmt", ratio_format_select, 0); // format back to 20.12
      rdchk(8'h02, 8'h80); // set by reset
      rdchk(8'h02, 8'h00); // cleared by read
      print_verdict();
   end
endmodule
